// file: hw/dopc_top.sv
// Function
// [R1] Strap low: spin up without start command
// [R2] Strap high: wait for start command
// [R3] Sample strap at power-on, hard, soft reset
// [R4] Write protect low refuses media-altering commands
// [R5] Write protect checked at every command
// [R6] Source mode drives one pulse per revolution
// [R7] Follower mode aligns spindle to received pulses
// [R8] Sync pulses are low-going both ways
// [R9] Lock setting selects sync pin use
// [R10] Host warns power loss 6 ms early
// [R11] Power warning stops activity, handles fault
// [R12] Factory test strap is ignored
// [R13] Activity LED output is active low
// [R14] Fault LED output lights an LED
// [R15] Programmable pin one under firmware only
// [R16] Programmable pin two left unconnected
// [R17] Sync settings: off, follower, source
// [R18] Sourced sync pulse lasts 2 us
// [R19] External sync pulse at least 1 us
// [R20] Inputs pass a two-flop synchronizer
`include "dopc_consts.svh"

module dopc_top #(
    parameter int REV_CYCLES = `DOPC_REV_CYC,   // Spindle revolution length
    parameter int SPIN_CYCLES = 4096             // Motor spin-up time model
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Option pins
    input wire logic i_auto_spin_n,
    input wire logic i_write_protect_n,
    input wire logic i_power_warn_n,
    input wire logic i_factory_test_strap_n,
    input wire logic i_prog2,
    // Shared open-drain sync line
    input wire logic i_sync_n,
    output logic o_sync_n,
    output logic o_sync_oe,
    // Programmable pin one
    input wire logic i_prog1,
    output logic o_prog1,
    output logic o_prog1_oe,
    // Indicators and motor
    output logic o_activity_led_n,
    output logic o_fault_led_n,
    output logic o_motor_on,
    output logic o_spindle_adjust
);
    import dopc_pkg::*;

    localparam int SYNC_OUT_CYC = `DOPC_SYNC_OUT_CYC;
    localparam int SYNC_IN_CYC = `DOPC_SYNC_IN_CYC;

    // Synchronizer stages: bit0 strap, 1 wp, 2 pwr, 3 sync, 4 prog1
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    // Register file
    logic [31:0] ctrl_ff;
    logic [31:0] gpio_ff;
    logic [7:0] stat_ff;
    // Strap capture request and pending
    logic [1:0] boot_ff; // Edges left before the power-on strap sample
    logic strap_req_ff; // Sample strap on the next edge
    logic strap_ff; // Strap level seen at the last sample
    logic start_cmd_ff; // Start unit command received
    // Motor
    dopc_motor_t motor_ff;
    logic [31:0] spin_cnt_ff;
    // Revolution and sync
    logic [31:0] rev_cnt_ff;
    logic [11:0] pulse_cnt_ff;
    logic [11:0] low_cnt_ff; // Low run on the received line, saturating
    logic pfail_ff; // Power warning seen, sticky

    // Register bus decode
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    dopc_sync_t sync_mode;
    logic rev_tick;
    logic sync_accept;

    // Unused pins: test strap and prog2 never reach logic
    // (the ports exist only so the connector is complete)  [R12] [R16]

    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && !i_penable && !i_pwrite;
    assign addr_ok = (i_paddr == `DOPC_OFF_CTRL) || (i_paddr == `DOPC_OFF_STAT) ||
                     (i_paddr == `DOPC_OFF_CMD) || (i_paddr == `DOPC_OFF_GPIO);
    // Reserved code 10 neither follows nor sources, but still sets pulse-seen
    assign sync_mode = dopc_sync_t'(ctrl_ff[`DOPC_CTRL_SYNC_LSB +: 2]);
    assign rev_tick = (rev_cnt_ff == 32'(REV_CYCLES - 1));
    // Accept a low pulse once it has held the minimum width
    assign sync_accept = (low_cnt_ff == 12'(SYNC_IN_CYC - 1)) && !sync2_ff[3]; // [R8] [R19]

    // Two-flop synchronizers, stage one read only by stage two
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_ff <= 5'h1F;
            sync2_ff <= 5'h1F;
        end else begin
            sync1_ff <= {i_prog1, i_sync_n, i_power_warn_n, i_write_protect_n, i_auto_spin_n}; // [R20]
            sync2_ff <= sync1_ff; // [R20]
        end
    end

    // APB answer: zero wait states, registered read data
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            // Ready in the access cycle only
            o_pready <= i_psel && !i_penable;
            // Unmapped offsets answer at once, with an error
            o_pslverr <= i_psel && !i_penable && !addr_ok;
            // Read data taken in setup, shown beside ready
            if (rd_en) begin
                unique case (i_paddr)
                    `DOPC_OFF_CTRL: o_prdata <= ctrl_ff;
                    `DOPC_OFF_STAT: o_prdata <= {24'h00_0000, stat_ff};
                    `DOPC_OFF_GPIO: o_prdata <= {gpio_ff[31:2], sync2_ff[4], gpio_ff[0]}; // [R15]
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control and firmware pin registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_ff <= `DOPC_CTRL_RESET;
            gpio_ff <= 32'h0000_0000;
        end else if (wr_en && o_pready) begin
            // Byte strobes honoured on both writable registers
            for (int b = 0; b < 4; b++) begin
                if (i_pstrb[b] && i_paddr == `DOPC_OFF_CTRL) begin
                    ctrl_ff[b*8 +: 8] <= i_pwdata[b*8 +: 8]; // [R9]
                end
                if (i_pstrb[b] && i_paddr == `DOPC_OFF_GPIO) begin
                    gpio_ff[b*8 +: 8] <= i_pwdata[b*8 +: 8]; // [R15]
                end
            end
        end else begin
            // Soft reset and start-unit bits self clear
            ctrl_ff[`DOPC_CTRL_SOFTRST_BIT] <= 1'b0;
            ctrl_ff[`DOPC_CTRL_SPIN_BIT] <= 1'b0;
        end
    end

    // Power-on delay: stage two holds its reset level for two edges,
    // so an earlier sample would always read the strap as inactive
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            boot_ff <= 2'h2;
        end else if (boot_ff != 2'h0) begin
            // Count down once, then rest
            boot_ff <= boot_ff - 2'h1;
        end
    end

    // Strap sampling after power-on/hard reset release and each soft reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_req_ff <= 1'b0;
            strap_ff <= 1'b0;
        end else begin
            // Request one edge ahead so the sample sees a settled stage two
            strap_req_ff <= ctrl_ff[`DOPC_CTRL_SOFTRST_BIT] || (boot_ff == 2'h1); // [R3]
            if (strap_req_ff) begin
                // Active low pin: low means spin up on its own
                strap_ff <= !sync2_ff[0]; // [R3]
            end
        end
    end

    // Start unit command latch; cleared by soft reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            start_cmd_ff <= 1'b0;
        end else if (ctrl_ff[`DOPC_CTRL_SPIN_BIT]) begin
            // Remembered until a soft reset
            start_cmd_ff <= 1'b1; // [R2]
        end else if (ctrl_ff[`DOPC_CTRL_SOFTRST_BIT]) begin
            start_cmd_ff <= 1'b0;
        end
    end

    // Power warning latch, sticky until reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pfail_ff <= 1'b0;
        end else if (!sync2_ff[2]) begin
            // Never cleared here: supply is about to go
            pfail_ff <= 1'b1; // [R11] [R10]
        end
    end

    // Motor state machine
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            motor_ff <= DOPC_MOT_STOP;
            spin_cnt_ff <= 32'h0000_0000;
        end else begin
            unique case (motor_ff)
                DOPC_MOT_STOP: begin
                    // Parked: wait for the strap or a start unit command
                    spin_cnt_ff <= 32'h0000_0000;
                    if (pfail_ff) begin
                        motor_ff <= DOPC_MOT_FAULT; // [R11]
                    end else if ((strap_ff && !strap_req_ff) || start_cmd_ff) begin
                        motor_ff <= DOPC_MOT_SPIN; // [R1] [R2]
                    end
                end
                DOPC_MOT_SPIN: begin
                    // Spin-up time is a model count, not a speed sensor
                    spin_cnt_ff <= spin_cnt_ff + 32'h0000_0001;
                    if (pfail_ff) begin
                        motor_ff <= DOPC_MOT_FAULT; // [R11]
                    end else if (spin_cnt_ff == 32'(SPIN_CYCLES - 1)) begin
                        motor_ff <= DOPC_MOT_READY; // [R1]
                    end
                end
                DOPC_MOT_READY: begin
                    // Ready for media access until power goes
                    if (pfail_ff) begin
                        motor_ff <= DOPC_MOT_FAULT; // [R11]
                    end
                end
                DOPC_MOT_FAULT: begin
                    // Power is going; stay parked until reset
                    motor_ff <= DOPC_MOT_FAULT;
                end
            endcase
        end
    end

    // Revolution counter; follower realigns to accepted pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rev_cnt_ff <= 32'h0000_0000;
        end else if (motor_ff == DOPC_MOT_STOP || motor_ff == DOPC_MOT_FAULT) begin
            rev_cnt_ff <= 32'h0000_0000;
        end else if (sync_mode == DOPC_SYNC_FOLLOW && sync_accept) begin
            // Follower snaps its phase to the accepted pulse
            rev_cnt_ff <= 32'h0000_0000; // [R7]
        end else if (rev_tick) begin
            rev_cnt_ff <= 32'h0000_0000;
        end else begin
            rev_cnt_ff <= rev_cnt_ff + 32'h0000_0001;
        end
    end

    // Low-width counter on the received line
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_cnt_ff <= 12'h000;
        end else begin
            if (sync2_ff[3]) begin
                // Line released: no pulse in progress
                low_cnt_ff <= 12'h000;
            end else if (low_cnt_ff != 12'hFFF) begin
                low_cnt_ff <= low_cnt_ff + 12'h001; // [R8]
            end
        end
    end

    // Source pulse: 2 us low per revolution, open drain
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pulse_cnt_ff <= 12'h000;
            o_sync_oe <= 1'b0;
            o_sync_n <= 1'b1;
        end else begin
            // Open drain: data stays low, only the enable moves
            o_sync_n <= 1'b0; // [R8]
            if (sync_mode == DOPC_SYNC_SOURCE && motor_ff == DOPC_MOT_READY && rev_tick) begin
                // New revolution: start a sourced pulse
                pulse_cnt_ff <= 12'(SYNC_OUT_CYC); // [R6] [R18]
                o_sync_oe <= 1'b1;
            end else if (pulse_cnt_ff > 12'h001) begin
                // Pulse runs out even if the mode changes meanwhile
                pulse_cnt_ff <= pulse_cnt_ff - 12'h001;
                o_sync_oe <= 1'b1; // [R18]
            end else begin
                // Released: the line's pull-up takes it high
                pulse_cnt_ff <= 12'h000;
                o_sync_oe <= 1'b0; // [R9] [R17]
            end
        end
    end

    // Outputs, status and command gating
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_ff <= 8'h00;
            o_activity_led_n <= 1'b1;
            o_fault_led_n <= 1'b1;
            o_motor_on <= 1'b0;
            o_spindle_adjust <= 1'b0;
            o_prog1 <= 1'b0;
            o_prog1_oe <= 1'b0;
        end else begin
            // Motor drive follows the state, one edge later
            o_motor_on <= (motor_ff == DOPC_MOT_SPIN) || (motor_ff == DOPC_MOT_READY);
            o_activity_led_n <= !(ctrl_ff[`DOPC_CTRL_ACT_BIT] && !pfail_ff); // [R13] [R11]
            o_fault_led_n <= !(ctrl_ff[`DOPC_CTRL_FAULT_BIT] || pfail_ff); // [R14]
            o_spindle_adjust <= (sync_mode == DOPC_SYNC_FOLLOW) && sync_accept; // [R7]
            o_prog1 <= gpio_ff[0]; // [R15]
            o_prog1_oe <= gpio_ff[1]; // [R15]
            stat_ff[`DOPC_ST_MOTOR_BIT] <= (motor_ff == DOPC_MOT_READY);
            stat_ff[`DOPC_ST_STRAP_BIT] <= strap_ff;
            stat_ff[`DOPC_ST_WP_BIT] <= !sync2_ff[1];
            stat_ff[`DOPC_ST_PFAIL_BIT] <= pfail_ff;
            stat_ff[`DOPC_ST_LOCKED_BIT] <= (sync_mode == DOPC_SYNC_FOLLOW) && sync_accept
                ? 1'b1 : (sync_mode == DOPC_SYNC_FOLLOW) && stat_ff[`DOPC_ST_LOCKED_BIT];
            // Sticky pulse-seen: set wins over write clear
            if (sync_accept && sync_mode != DOPC_SYNC_OFF) begin
                stat_ff[`DOPC_ST_SYNCSEEN_BIT] <= 1'b1;
            end else if (wr_en && o_pready && i_paddr == `DOPC_OFF_STAT) begin
                stat_ff[`DOPC_ST_SYNCSEEN_BIT] <= 1'b0;
            end
            // Each command samples write protect afresh
            if (wr_en && o_pready && i_paddr == `DOPC_OFF_CMD) begin
                stat_ff[`DOPC_ST_DONE_BIT] <= 1'b1; // [R5]
                stat_ff[`DOPC_ST_REFUSED_BIT] <= i_pwdata[`DOPC_CMD_ALTER_BIT] &&
                    (!sync2_ff[1] || pfail_ff); // [R4] [R5]
            end
        end
    end

endmodule

// file: pkg/dopc_consts.svh
`ifndef DOPC_CONSTS_SVH
`define DOPC_CONSTS_SVH

// Register byte offsets
`define DOPC_OFF_CTRL 12'h000
`define DOPC_OFF_STAT 12'h004
`define DOPC_OFF_CMD 12'h008
`define DOPC_OFF_GPIO 12'h00C

// Control register fields
`define DOPC_CTRL_SYNC_LSB 0
`define DOPC_CTRL_ACT_BIT 2
`define DOPC_CTRL_FAULT_BIT 3
`define DOPC_CTRL_SPIN_BIT 4
`define DOPC_CTRL_SOFTRST_BIT 5
`define DOPC_CTRL_RESET 32'h0000_0000

// Command register fields (write launches a command)
`define DOPC_CMD_ALTER_BIT 0

// Status register fields
`define DOPC_ST_MOTOR_BIT 0
`define DOPC_ST_STRAP_BIT 1
`define DOPC_ST_WP_BIT 2
`define DOPC_ST_PFAIL_BIT 3
`define DOPC_ST_REFUSED_BIT 4
`define DOPC_ST_DONE_BIT 5
`define DOPC_ST_SYNCSEEN_BIT 6
`define DOPC_ST_LOCKED_BIT 7

// Timing
`define DOPC_CLK_MHZ 125
`define DOPC_SYNC_OUT_NS 2000
`define DOPC_SYNC_IN_MIN_NS 1000
`define DOPC_SYNC_OUT_CYC ((`DOPC_SYNC_OUT_NS * `DOPC_CLK_MHZ) / 1000)
`define DOPC_SYNC_IN_CYC ((`DOPC_SYNC_IN_MIN_NS * `DOPC_CLK_MHZ + 999) / 1000)
`define DOPC_REV_CYC 1041625

`endif

// file: pkg/dopc_pkg.sv
package dopc_pkg;
    // Spindle lock setting
    typedef enum logic [1:0] {
        DOPC_SYNC_OFF = 2'b00,
        DOPC_SYNC_FOLLOW = 2'b01,
        DOPC_SYNC_SOURCE = 2'b11
    } dopc_sync_t;
    // Motor state, Gray along stopped-spinning-ready
    typedef enum logic [1:0] {
        DOPC_MOT_STOP = 2'b00,
        DOPC_MOT_SPIN = 2'b01,
        DOPC_MOT_READY = 2'b11,
        DOPC_MOT_FAULT = 2'b10
    } dopc_motor_t;
endpackage

// file: tb/dopc_chk.sv
`include "dopc_consts.svh"

module dopc_chk #(
    parameter int REV_CYCLES = 1000 // Revolution length
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Watched pins
    input wire logic i_auto_spin_n,
    input wire logic i_power_warn_n,
    input wire logic i_sync_n,
    input wire logic o_sync_n,
    input wire logic o_sync_oe,
    input wire logic o_fault_led_n,
    input wire logic o_motor_on,
    input wire logic o_spindle_adjust
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic [9:0] hi_ff; // Cycles the pin is sunk
    logic [31:0] gap_ff; // Cycles since last sourced pulse
    logic had_ff; // First pulse has no period yet
    logic [7:0] lo_ff; // Current low run on the line
    logic [7:0] last_ff; // Last finished low run

    // Sourced pulse width and spacing
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hi_ff <= '0;
            gap_ff <= '0;
            had_ff <= 1'b0;
        end else begin
            hi_ff <= o_sync_oe ? hi_ff + 10'h001 : '0;
            gap_ff <= $rose(o_sync_oe) ? 32'h0000_0001 : gap_ff + 32'h0000_0001;
            had_ff <= had_ff | $rose(o_sync_oe);
        end
    end

    // Low runs, saturating so a stuck line cannot wrap
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lo_ff <= '0;
            last_ff <= '0;
        end else begin
            lo_ff <= i_sync_n ? 8'h00 : (lo_ff == 8'hFF ? lo_ff : lo_ff + 8'h01);
            last_ff <= (i_sync_n && lo_ff != 8'h00) ? lo_ff : last_ff;
        end
    end

    sequence start_s;
        $rose(i_reset_n) && !i_auto_spin_n;
    endsequence
    sequence warn_s;
        !i_power_warn_n [*3];
    endsequence

    auto_start_a: assert property (start_s |-> ##[1:8] o_motor_on)
        else $error("motor not started by strap");
    strap_idle_a: assert property ($rose(i_reset_n) && i_auto_spin_n |-> !o_motor_on [*8])
        else $error("motor started without command");
    power_fault_a: assert property (warn_s |-> ##[0:3] (!o_fault_led_n && !o_motor_on))
        else $error("power warning not handled");
    sync_drive_a: assert property (o_sync_oe |-> !o_sync_n && o_motor_on)
        else $error("sync pin driven wrongly");
    pulse_width_a: assert property ($fell(o_sync_oe) |-> hi_ff == `DOPC_SYNC_OUT_CYC)
        else $error("sourced pulse width wrong");
    rev_period_a: assert property ($rose(o_sync_oe) && had_ff |-> gap_ff == REV_CYCLES)
        else $error("sourced pulse period wrong");
    follow_width_a: assert property (o_spindle_adjust |->
        lo_ff >= `DOPC_SYNC_IN_CYC || last_ff >= `DOPC_SYNC_IN_CYC)
        else $error("short pulse accepted");
    adjust_pulse_a: assert property (o_spindle_adjust |=> !o_spindle_adjust)
        else $error("adjust pulse too long");
endmodule

bind dopc_top dopc_chk #(.REV_CYCLES(REV_CYCLES)) chk_i (.i_clk, .i_reset_n, .i_auto_spin_n, .i_power_warn_n,
    .i_sync_n, .o_sync_n, .o_sync_oe, .o_fault_led_n, .o_motor_on, .o_spindle_adjust);

// file: tb/dopc_backplane.sv
module dopc_backplane (
    // Clock
    input wire logic i_clk,
    // Drive side of the sync pin
    input wire logic i_oe,
    input wire logic i_drv_n,
    // Lines seen by the drive
    output logic o_sync_n,
    output logic o_power_warn_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ext_low; // Another drive sinks the line

    initial begin
        ext_low = 1'b0;
        o_power_warn_n = 1'b1;
    end

    // Pulled up unless some party sinks it
    assign o_sync_n = !((i_oe && !i_drv_n) || ext_low);

    // Low pulse from another source, length chosen by the caller
    task automatic pulse(input int len);
        ext_low <= 1'b1;
        repeat (len) @(posedge i_clk);
        ext_low <= 1'b0;
    endtask

    // Warning held until supply goes away
    task automatic warn();
        o_power_warn_n <= 1'b0;
    endtask
endmodule

// file: tb/drive_option_pin_control_tb_top.sv
`include "dopc_consts.svh"

module drive_option_pin_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_reset_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, q, prev;
    logic [3:0] i_pstrb;
    logic i_auto_spin_n, i_write_protect_n, i_power_warn_n, i_factory_test_strap_n, i_prog2;
    logic i_sync_n, o_sync_n, o_sync_oe, i_prog1, o_prog1, o_prog1_oe;
    logic o_activity_led_n, o_fault_led_n, o_motor_on, o_spindle_adjust;
    int miscompares, compares, c;

    // Short revolution and spin-up keep the run brief
    dopc_top #(.REV_CYCLES(1000), .SPIN_CYCLES(16)) dut (.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_auto_spin_n, .i_write_protect_n,
        .i_power_warn_n, .i_factory_test_strap_n, .i_prog2, .i_sync_n, .o_sync_n, .o_sync_oe, .i_prog1,
        .o_prog1, .o_prog1_oe, .o_activity_led_n, .o_fault_led_n, .o_motor_on, .o_spindle_adjust);
    dopc_backplane bp (.i_clk, .i_oe(o_sync_oe), .i_drv_n(o_sync_n), .o_sync_n(i_sync_n),
        .o_power_warn_n(i_power_warn_n));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rst();
        i_reset_n <= 1'b0;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
    endtask

    // Rising edges of adjust (sel high) or sync drive
    task automatic count_rise(input logic sel, input int cyc, output int n);
        logic p;
        logic s;
        p = sel ? o_spindle_adjust : o_sync_oe;
        n = 0;
        repeat (cyc) begin
            @(posedge i_clk);
            s = sel ? o_spindle_adjust : o_sync_oe;
            if (s === 1'b1 && p !== 1'b1) n++;
            p = s;
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_prog1, i_prog2, i_auto_spin_n} <= '0;
        {i_write_protect_n, i_factory_test_strap_n, i_pstrb} <= 6'h3F;
        miscompares = 0;
        compares = 0;
        rst();
        repeat (30) @(posedge i_clk);
        apb(0, `DOPC_OFF_STAT, 0);
        chk(q[1:0], 2'b11);
        // Readback: bit 1 shows the pin level, bit 0 the output latch
        for (int v = 0; v < 2; v++) begin
            i_prog1 <= v[0];
            apb(1, `DOPC_OFF_GPIO, {30'h0, v[0], v[0]});
            repeat (3) @(posedge i_clk);
            chk({o_prog1, o_prog1_oe}, {v[0], v[0]});
            apb(0, `DOPC_OFF_GPIO, 0);
            chk(q[1:0], {v[0], v[0]});
        end
        apb(1, `DOPC_OFF_CTRL, 32'h0000_000C);
        repeat (3) @(posedge i_clk);
        chk({o_activity_led_n, o_fault_led_n}, 2'b00);
        apb(1, `DOPC_OFF_CTRL, 0);
        repeat (3) @(posedge i_clk);
        chk({o_activity_led_n, o_fault_led_n}, 2'b11);
        // Altering, harmless, altering once unprotected
        for (int i = 0; i < 3; i++) begin
            i_write_protect_n <= (i == 2);
            repeat (4) @(posedge i_clk);
            apb(1, `DOPC_OFF_CMD, i != 1);
            repeat (3) @(posedge i_clk);
            apb(0, `DOPC_OFF_STAT, 0);
            chk(q[4], i == 0);
        end
        prev = q;
        i_factory_test_strap_n <= 1'b0;
        i_prog2 <= 1'b1;
        repeat (5) @(posedge i_clk);
        apb(0, `DOPC_OFF_STAT, 0);
        chk(q, prev);
        apb(0, 12'h010, 0);
        chk(err, 1'b1);
        chk(q, 0);
        apb(1, `DOPC_OFF_CTRL, 32'h0000_0003);
        for (int n = 0; n < 2000 && o_sync_oe !== 1'b1; n++) @(posedge i_clk);
        chk({o_sync_oe, i_sync_n}, 2'b10);
        count_rise(1'b0, 2300, c);
        chk(c, 2);
        apb(1, `DOPC_OFF_CTRL, 0);
        count_rise(1'b0, 1100, c);
        chk(c, 0);
        // Off, follow, code 10, then a follow pulse too short
        for (int i = 0; i < 4; i++) begin
            apb(1, `DOPC_OFF_CTRL, (i == 3) ? 32'h0000_0001 : i);
            fork
                bp.pulse(i == 3 ? 60 : `DOPC_SYNC_IN_CYC + 5);
                count_rise(1'b1, 160, c);
            join
            chk(c, i == 1);
        end
        i_auto_spin_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        apb(1, `DOPC_OFF_CTRL, 32'h0000_0020);
        repeat (4) @(posedge i_clk);
        apb(0, `DOPC_OFF_STAT, 0);
        chk(q[1], 1'b0);
        rst();
        repeat (40) @(posedge i_clk);
        chk(o_motor_on, 1'b0);
        apb(1, `DOPC_OFF_CTRL, 32'h0000_0010);
        repeat (25) @(posedge i_clk);
        apb(0, `DOPC_OFF_STAT, 0);
        chk({o_motor_on, q[0]}, 2'b11);
        apb(1, `DOPC_OFF_CTRL, 32'h0000_0004);
        bp.warn();
        repeat (8) @(posedge i_clk);
        chk({o_fault_led_n, o_activity_led_n, o_motor_on}, 3'b010);
        apb(1, `DOPC_OFF_CMD, 1);
        apb(0, `DOPC_OFF_STAT, 0);
        chk(q[4:3], 2'b11);
        print_verdict();
    end

    // Whole run is under 10000 cycles
    initial begin
        repeat (60000) @(posedge i_clk);
        miscompares++;
        print_verdict();
    end
endmodule
